// [core/gate_regs_if.sv]
/*
 interface carrying the three gate words from register file to gate select.
 assumes both ends share CLK.
*/
`timescale 1ns/10ps
interface gate_regs_if;
  logic [31:0] run_gates;
  logic [31:0] sleep_gates;
  logic [31:0] deep_gates;
  logic auto_gating_enable;
  logic [1:0] mode;
  logic [31:0] active_gates;
  modport regs (output run_gates, sleep_gates, deep_gates,
    auto_gating_enable, mode, input active_gates);
  modport sel (input run_gates, sleep_gates, deep_gates,
    auto_gating_enable, mode, output active_gates);
endinterface : gate_regs_if

// [core/gate_select.sv]
/*
 chooses the gate word that is in force for the present power mode.
 assumes mode and words are registered on CLK.
*/
`timescale 1ns/10ps
module gate_select (
  input wire logic CLK,
  input wire logic RST_B,
  gate_regs_if.sel g
);
  logic [31:0] active_next;
  logic [31:0] active_reg;

  always_comb begin
    case (g.mode)
      sleep_gate_pkg::MODE_SLEEP: begin
        // sleep word only with auto gating, else run word holds
        active_next = g.auto_gating_enable ? g.sleep_gates
          : g.run_gates;
      end
      sleep_gate_pkg::MODE_DEEP: begin
        active_next = g.auto_gating_enable ? g.deep_gates
          : g.run_gates;
      end
      default: begin
        active_next = g.run_gates;
      end
    endcase
  end

  // registered so the enables never glitch into the gate cells
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      active_reg <= sleep_gate_pkg::GATES_RESET;
    end else begin
      active_reg <= active_next & sleep_gate_pkg::GATES_WRITABLE;
    end
  end

  assign g.active_gates = active_reg;
endmodule : gate_select

// [core/sleep_clock_gating.sv]
/*
 sleep-mode unit clock gate register with wishbone slave, clock enables,
 bus-fault check for peripheral accesses and an event interrupt.
 assumes one clock, an asynchronous active-low reset, and that the power
 mode input comes from logic on the same clock.
*/
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
module sleep_clock_gating (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  input wire logic [1:0] POWER_MODE,
  input wire logic [31:0] UNIT_ACCESS,
  output logic UNIT_FAULT,
  output logic [31:0] UNIT_CLOCK_ENABLE,
  output logic IRQ
);
  gate_regs_if g ();

  logic [31:0] run_reg;
  logic [31:0] sleep_reg;
  logic [31:0] deep_reg;
  logic [2:0] control_reg;
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic [3:0] mask_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic ack_reg;
  logic err_reg;
  logic fault_reg;
  logic [31:0] prev_active_reg;
  logic [1:0] prev_mode_reg;
  sleep_gate_pkg::bus_state_e state_reg;
  sleep_gate_pkg::bus_state_e state_next;
  logic req;
  logic wr;
  logic rd;
  logic mapped;
  logic fault_now;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    // reserved bits stay zero whatever is written
    merge = ((old & ~m) | (data & m)) & sleep_gate_pkg::GATES_WRITABLE;
  endfunction : merge

  function automatic logic hit(input logic [11:0] adr,
    input logic [11:0] off);
    hit = (adr[11:2] == off[11:2]);
  endfunction : hit

  assign req = CYC_I && STB_I && (state_reg == sleep_gate_pkg::ST_IDLE);
  assign mapped = hit(ADR_I, sleep_gate_pkg::SLEEP_GATES_OFFSET)
    || hit(ADR_I, sleep_gate_pkg::RUN_GATES_OFFSET)
    || hit(ADR_I, sleep_gate_pkg::DEEP_GATES_OFFSET)
    || hit(ADR_I, sleep_gate_pkg::CONTROL_OFFSET)
    || hit(ADR_I, sleep_gate_pkg::EVENT_STATUS_OFFSET)
    || hit(ADR_I, sleep_gate_pkg::EVENT_MASK_OFFSET);
  assign wr = req && WE_I && mapped;
  assign rd = req && !WE_I && mapped;

  always_comb begin
    case (state_reg)
      sleep_gate_pkg::ST_IDLE: begin
        state_next = req ? sleep_gate_pkg::ST_ACK : sleep_gate_pkg::ST_IDLE;
      end
      default: begin
        state_next = sleep_gate_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= sleep_gate_pkg::ST_IDLE;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg <= req && mapped;
      err_reg <= req && !mapped;
    end
  end

  // gate words
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sleep_reg <= sleep_gate_pkg::GATES_RESET;
      run_reg <= sleep_gate_pkg::GATES_RESET;
      deep_reg <= sleep_gate_pkg::GATES_RESET;
    end else if (wr) begin
      if (hit(ADR_I, sleep_gate_pkg::SLEEP_GATES_OFFSET)) begin
        sleep_reg <= merge(sleep_reg, DAT_I, SEL_I);
      end
      if (hit(ADR_I, sleep_gate_pkg::RUN_GATES_OFFSET)) begin
        run_reg <= merge(run_reg, DAT_I, SEL_I);
      end
      if (hit(ADR_I, sleep_gate_pkg::DEEP_GATES_OFFSET)) begin
        deep_reg <= merge(deep_reg, DAT_I, SEL_I);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      control_reg <= 3'h0;
      mask_reg <= sleep_gate_pkg::EVENT_RESET;
    end else if (wr && SEL_I[0]) begin
      if (hit(ADR_I, sleep_gate_pkg::CONTROL_OFFSET)) begin
        control_reg <= {DAT_I[sleep_gate_pkg::MODE_LSB +: 2],
          DAT_I[sleep_gate_pkg::AUTO_GATING_BIT]};
      end
      if (hit(ADR_I, sleep_gate_pkg::EVENT_MASK_OFFSET)) begin
        mask_reg <= DAT_I[3:0];
      end
    end
  end

  assign g.run_gates = run_reg;
  assign g.sleep_gates = sleep_reg;
  assign g.deep_gates = deep_reg;
  assign g.auto_gating_enable = control_reg[0];
  assign g.mode = POWER_MODE;

  gate_select u_sel (
    .CLK(CLK),
    .RST_B(RST_B),
    .g(g)
  );

  assign UNIT_CLOCK_ENABLE = g.active_gates;

  // a unit whose enable is low cannot answer, so flag the access
  assign fault_now = |(UNIT_ACCESS & ~g.active_gates);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fault_reg <= 1'b0;
      prev_active_reg <= sleep_gate_pkg::GATES_RESET;
      prev_mode_reg <= 2'h0;
    end else begin
      fault_reg <= fault_now;
      prev_active_reg <= g.active_gates;
      prev_mode_reg <= POWER_MODE;
    end
  end

  assign UNIT_FAULT = fault_reg;

  // events: set beats the clear-on-read in the same cycle
  always_comb begin
    status_next = status_reg;
    if (rd && hit(ADR_I, sleep_gate_pkg::EVENT_STATUS_OFFSET)) begin
      status_next = sleep_gate_pkg::EVENT_RESET;
    end
    if (fault_now) begin
      status_next[sleep_gate_pkg::EV_FAULT_BIT] = 1'b1;
    end
    if (prev_mode_reg != POWER_MODE) begin
      status_next[sleep_gate_pkg::EV_MODE_BIT] = 1'b1;
    end
    if (prev_active_reg != g.active_gates) begin
      status_next[sleep_gate_pkg::EV_GATES_BIT] = 1'b1;
    end
    if (req && !mapped) begin
      status_next[sleep_gate_pkg::EV_UNMAPPED_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_reg <= sleep_gate_pkg::EVENT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  assign IRQ = |(status_reg & mask_reg);

  always_comb begin
    dat_next = 32'h0000_0000;
    if (hit(ADR_I, sleep_gate_pkg::SLEEP_GATES_OFFSET)) begin
      dat_next = sleep_reg;
    end else if (hit(ADR_I, sleep_gate_pkg::RUN_GATES_OFFSET)) begin
      dat_next = run_reg;
    end else if (hit(ADR_I, sleep_gate_pkg::DEEP_GATES_OFFSET)) begin
      dat_next = deep_reg;
    end else if (hit(ADR_I, sleep_gate_pkg::CONTROL_OFFSET)) begin
      dat_next = {29'h0000_0000, control_reg};
    end else if (hit(ADR_I, sleep_gate_pkg::EVENT_STATUS_OFFSET)) begin
      dat_next = {28'h000_0000, status_reg};
    end else if (hit(ADR_I, sleep_gate_pkg::EVENT_MASK_OFFSET)) begin
      dat_next = {28'h000_0000, mask_reg};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dat_reg <= 32'h0000_0000;
    end else if (rd) begin
      dat_reg <= dat_next;
    end
  end

  assign DAT_O = dat_reg;
  assign ACK_O = ack_reg;
  assign ERR_O = err_reg;
endmodule : sleep_clock_gating

// [core/sleep_gate_pkg.sv]
/*
 sleep-mode unit clock gate register: offsets, field layout, reset values.
 assumes a classic wishbone register bus on one clock, CLK at 125 MHz.
*/
// How it works
// - gate register sits at byte offset 0x114, reads all zero after reset
// - a set gate bit clocks its unit; a clear bit leaves it unclocked
// - peripheral access to an unclocked unit gets a bus fault, not a transfer
// - all gate bits are zero after reset
// - run gates apply running, sleep gates in sleep, deep gates in deep sleep
// - sleep and deep gates only count when auto gating enable is set
// - bit 24 gates comparator zero
// - bits 19 to 16 gate general-purpose counters three to zero
// - bit 12 gates two-wire unit zero
// - bits 5 and 4 gate synchronous serial units one and zero
// - bits 2 to 0 gate serial ports two to zero
// - reserved bits read zero and ignore writes
package sleep_gate_pkg;
  localparam logic [11:0] SLEEP_GATES_OFFSET = 12'h114;
  localparam logic [11:0] RUN_GATES_OFFSET = 12'h104;
  localparam logic [11:0] DEEP_GATES_OFFSET = 12'h124;
  localparam logic [11:0] CONTROL_OFFSET = 12'h200;
  localparam logic [11:0] EVENT_STATUS_OFFSET = 12'h204;
  localparam logic [11:0] EVENT_MASK_OFFSET = 12'h208;
  localparam logic [31:0] GATES_RESET = 32'h0000_0000;
  localparam logic [31:0] GATES_WRITABLE = 32'h010F_1037;
  localparam int COMPARATOR_ZERO_BIT = 24;
  localparam int GP_COUNTER_ZERO_BIT = 16;
  localparam int TWO_WIRE_ZERO_BIT = 12;
  localparam int SYNC_SERIAL_ZERO_BIT = 4;
  localparam int SERIAL_PORT_ZERO_BIT = 0;
  localparam int AUTO_GATING_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_MODE_BIT = 1;
  localparam int EV_GATES_BIT = 2;
  localparam int EV_UNMAPPED_BIT = 3;
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_e;
  typedef enum {ST_IDLE, ST_ACK} bus_state_e;
endpackage : sleep_gate_pkg

// [test/gated_units.sv]
/* model of the peripheral units that sit behind the clock enables.
 assumes the bench names a unit and pulses go on clk. */
`timescale 1ns/10ps
module gated_units (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [4:0] unit,
  output logic [31:0] access
);
  // one-cycle access to a single unit, never held, so each refusal
  // can be traced to exactly one request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) access <= 32'h0;
    else access <= go ? (32'h1 << unit) : 32'h0;
  end
endmodule : gated_units

// [test/sleep_gate_properties.sv]
/* timing and value checks at the ports of the sleep gate block.
 assumes the top ports only; bound at the foot of this file. */
`timescale 1ns/10ps
module sleep_gate_properties (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [11:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic [1:0] POWER_MODE,
  input wire logic [31:0] UNIT_ACCESS,
  input wire logic UNIT_FAULT,
  input wire logic [31:0] UNIT_CLOCK_ENABLE,
  input wire logic IRQ
);
  logic req;
  logic hit;
  logic lost;
  assign req = CYC_I && STB_I && !ACK_O && !ERR_O;
  assign hit = ADR_I[11:2] inside {10'h041, 10'h045, 10'h049, 10'h080,
    10'h081, 10'h082};
  assign lost = |(UNIT_ACCESS & ~UNIT_CLOCK_ENABLE);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_MAPPED_ACK: assert property (req && hit |=> ACK_O && !ERR_O)
    else $error("mapped access not acked");
  AST_UNMAPPED_ERR: assert property (req && !hit |=> ERR_O && !ACK_O)
    else $error("unmapped access not refused");
  AST_RES_ZERO: assert property ((UNIT_CLOCK_ENABLE
    & ~sleep_gate_pkg::GATES_WRITABLE) == 32'h0)
    else $error("reserved enable set");
  AST_READ_RES: assert property (ACK_O && $past(!WE_I
    && ADR_I[11:2] == 10'h045)
    |-> (DAT_O & ~sleep_gate_pkg::GATES_WRITABLE) == 32'h0)
    else $error("reserved gate bit read back set");
  AST_FAULT: assert property (lost |=> UNIT_FAULT)
    else $error("no fault on unclocked unit");
  AST_NO_FAULT: assert property (!lost |=> !UNIT_FAULT)
    else $error("fault on clocked unit");
  AST_SLEEP_IGNORED: assert property (ACK_O && $past(WE_I)
    && $past(ADR_I[11:2]) == 10'h045 && POWER_MODE == 2'h0
    && $past(POWER_MODE) == 2'h0 && $past(POWER_MODE, 2) == 2'h0
    |=> $stable(UNIT_CLOCK_ENABLE) [*2])
    else $error("sleep word changed enables while running");
  AST_RESET_ZERO: assert property ($rose(RST_B)
    |-> UNIT_CLOCK_ENABLE == 32'h0 && !IRQ && !ACK_O)
    else $error("outputs not clear after reset");
endmodule : sleep_gate_properties

bind sleep_clock_gating sleep_gate_properties i_props (.CLK(CLK),
  .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .POWER_MODE(POWER_MODE),
  .UNIT_ACCESS(UNIT_ACCESS), .UNIT_FAULT(UNIT_FAULT),
  .UNIT_CLOCK_ENABLE(UNIT_CLOCK_ENABLE), .IRQ(IRQ));

// [test/tb.sv]
/* self-checking bench for the sleep gate block.
 assumes the checker is bound and the unit model is in test/. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic CYC_I = 1'b0;
  logic STB_I = 1'b0;
  logic WE_I = 1'b0;
  logic [11:0] ADR_I = 12'h000;
  logic [31:0] DAT_I = 32'h0;
  logic [1:0] POWER_MODE = 2'h0;
  logic go = 1'b0;
  logic [4:0] unit = 5'h00;
  logic [31:0] DAT_O, UNIT_ACCESS, UNIT_CLOCK_ENABLE, q;
  logic ACK_O, ERR_O, UNIT_FAULT, IRQ, err;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rows [7][2] = '{'{32'hFFFFFFFF, 32'h010F1037},
    '{32'h01000000, 32'h01000000}, '{32'h000F0000, 32'h000F0000},
    '{32'h00001000, 32'h00001000}, '{32'h00000030, 32'h00000030},
    '{32'hFEF0EFC8, 32'h0}, '{32'h00000007, 32'h00000007}};
  // mode, auto gating, enables expected
  logic [31:0] modes [4][3] = '{'{32'h1, 32'h1, 32'h00000017},
    '{32'h2, 32'h1, 32'h01000000}, '{32'h0, 32'h1, 32'h00010000},
    '{32'h1, 32'h0, 32'h00010000}};
  sleep_clock_gating i_dut (.CLK(CLK), .RST_B(RST_B), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(4'hF), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .POWER_MODE(POWER_MODE),
    .UNIT_ACCESS(UNIT_ACCESS), .UNIT_FAULT(UNIT_FAULT),
    .UNIT_CLOCK_ENABLE(UNIT_CLOCK_ENABLE), .IRQ(IRQ));
  gated_units i_units (.clk(CLK), .rst_b(RST_B), .go(go), .unit(unit),
    .access(UNIT_ACCESS));
  always #4 CLK = ~CLK;
  task finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  task automatic wb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= d;
    do @(posedge CLK); while (ACK_O !== 1'b1 && ERR_O !== 1'b1);
    q = DAT_O;
    err = ERR_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge CLK);
  endtask : wb
  // single access to one unit, fault is registered one edge later
  task automatic poke(input logic [4:0] u);
    go <= 1'b1;
    unit <= u;
    @(posedge CLK);
    go <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : poke
  initial begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    `CHK("enables", 32'h0, UNIT_CLOCK_ENABLE)
    wb(1'b0, 12'h114, 32'h0);
    `CHK("reset", sleep_gate_pkg::GATES_RESET, q)
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, 12'h114, rows[i][0]);
      wb(1'b0, 12'h114, 32'h0);
      `CHK("gates", rows[i][1], q)
    end
    wb(1'b0, 12'h114, 32'h0);
    wb(1'b1, 12'h114, q | 32'h00000010);
    wb(1'b1, 12'h104, 32'h00010000);
    wb(1'b1, 12'h124, 32'h01000000);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 12'h200, modes[i][1]);
      POWER_MODE <= modes[i][0][1:0];
      repeat (4) @(posedge CLK);
      `CHK("mode", modes[i][2], UNIT_CLOCK_ENABLE)
    end
    wb(1'b1, 12'h200, 32'h1);
    repeat (4) @(posedge CLK);
    wb(1'b1, 12'h208, 32'h1);
    wb(1'b0, 12'h204, 32'h0);
    poke(5'd4);
    `CHK("fault", 1'b0, UNIT_FAULT)
    poke(5'd5);
    `CHK("fault", 1'b1, UNIT_FAULT)
    repeat (3) @(posedge CLK);
    `CHK("irq", 1'b1, IRQ)
    wb(1'b0, 12'h204, 32'h0);
    `CHK("status", 1'b1, q[0])
    `CHK("irq", 1'b0, IRQ)
    wb(1'b1, 12'h208, 32'h0);
    poke(5'd5);
    repeat (3) @(posedge CLK);
    `CHK("irq", 1'b0, IRQ)
    wb(1'b1, 12'h300, 32'hFFFFFFFF);
    `CHK("err", 1'b1, err)
    wb(1'b0, 12'h204, 32'h0);
    `CHK("status", 1'b1, q[3])
    finish_test();
  end
endmodule : tb
